// File: ccc_pkg.sv
// package for the clear, call, complement and watchdog-kick execute block
// assumes a 14-bit instruction word, 13-bit program counter and 8-bit data path
package ccc_pkg;

	localparam int CCC_INSTR_W = 14;
	localparam int CCC_PC_W = 13;
	localparam int CCC_DATA_W = 8;
	localparam int CCC_FADDR_W = 7;
	localparam int CCC_STACK_DEPTH = 8;
	localparam int CCC_CYCLE_CLOCKS = 4;
	localparam int CCC_WATCHDOG_PRE_W = 8;
	localparam int CCC_WATCHDOG_CNT_W = 8;

	// field positions inside the instruction word and the PC high latch
	localparam int CCC_TARGET_W = 11;
	localparam int CCC_DEST_BIT = 7;
	localparam int CCC_LATCH_LSB = 3;
	localparam int CCC_LATCH_W = 5;

	// opcode patterns and the masks that select their fixed bits
	localparam logic [13:0] CCC_CLEAR_FILE_PAT = 14'h0180;
	localparam logic [13:0] CCC_CLEAR_FILE_MASK = 14'h3f80;
	localparam logic [13:0] CCC_CLEAR_ACC_PAT = 14'h0100;
	localparam logic [13:0] CCC_CLEAR_ACC_MASK = 14'h3f80;
	localparam logic [13:0] CCC_KICK_PAT = 14'h0064;
	localparam logic [13:0] CCC_KICK_MASK = 14'h3fff;
	localparam logic [13:0] CCC_INVERT_PAT = 14'h0900;
	localparam logic [13:0] CCC_INVERT_MASK = 14'h3f00;
	localparam logic [13:0] CCC_CALL_PAT = 14'h2000;
	localparam logic [13:0] CCC_CALL_MASK = 14'h3800;

	// values after reset and cleared values
	localparam logic [12:0] CCC_PC_RST = 13'h0000;
	localparam logic [7:0] CCC_CLEARED = 8'h00;
	localparam logic CCC_FLAG_RST = 1'b1;

	typedef enum logic [2:0] {
		OP_NONE,
		OP_CLEAR_FILE,
		OP_CLEAR_ACC,
		OP_KICK,
		OP_INVERT,
		OP_CALL
	} ccc_op_t;

	function automatic ccc_op_t ccc_decode(input logic [13:0] word);
		ccc_op_t op;
		op = OP_NONE;
		if ((word & CCC_CLEAR_FILE_MASK) == CCC_CLEAR_FILE_PAT) begin
			op = OP_CLEAR_FILE;
		end else if ((word & CCC_CLEAR_ACC_MASK) == CCC_CLEAR_ACC_PAT) begin
			op = OP_CLEAR_ACC;
		end else if ((word & CCC_KICK_MASK) == CCC_KICK_PAT) begin
			op = OP_KICK;
		end else if ((word & CCC_INVERT_MASK) == CCC_INVERT_PAT) begin
			op = OP_INVERT;
		end else if ((word & CCC_CALL_MASK) == CCC_CALL_PAT) begin
			op = OP_CALL;
		end
		return op;
	endfunction

endpackage

// File: ccc_cycle_div.sv
// instruction-cycle divider: one-cycle enable every CYCLES clocks
// assumes a single clock and a synchronous active-high reset
module ccc_cycle_div
	import ccc_pkg::*;
#(
	parameter int CYCLES = CCC_CYCLE_CLOCKS
) (
	input wire logic clock_in,
	input wire logic reset_in,
	output logic cycle_en_out
);

	localparam int CNT_W = (CYCLES > 1) ? $clog2(CYCLES) : 1;
	localparam logic [CNT_W-1:0] LAST = CNT_W'(CYCLES - 1);

	typedef struct packed {
		logic [CNT_W-1:0] cnt;
		logic en;
	} ccc_div_st_t;

	ccc_div_st_t st_q;
	ccc_div_st_t st_d;

	always_comb begin
		st_d = st_q;
		st_d.en = (st_q.cnt == LAST);
		st_d.cnt = (st_q.cnt == LAST) ? '0 : st_q.cnt + 1'b1;
	end

	always_ff @(posedge clock_in) begin
		if (reset_in) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign cycle_en_out = st_q.en;

endmodule

// File: ccc_watchdog.sv
// watchdog counter with its prescaler, cleared by the kick opcode
// assumes tick_in is a one-cycle enable; the clear wins over a tick
module ccc_watchdog
	import ccc_pkg::*;
#(
	parameter int PRE_W = CCC_WATCHDOG_PRE_W,
	parameter int CNT_W = CCC_WATCHDOG_CNT_W
) (
	input wire logic clock_in,
	input wire logic reset_in,
	input wire logic tick_in,
	input wire logic clear_in,
	output logic [CNT_W-1:0] count_out,
	output logic [PRE_W-1:0] prescale_out,
	output logic expired_out
);

	typedef struct packed {
		logic [PRE_W-1:0] pre;
		logic [CNT_W-1:0] cnt;
		logic expired;
	} ccc_wd_st_t;

	ccc_wd_st_t st_q;
	ccc_wd_st_t st_d;

	always_comb begin
		st_d = st_q;
		st_d.expired = 1'b0;
		if (clear_in) begin
			st_d.pre = '0;
			st_d.cnt = '0;
		end else if (tick_in) begin
			st_d.pre = st_q.pre + 1'b1;
			if (&st_q.pre) begin
				st_d.cnt = st_q.cnt + 1'b1;
				st_d.expired = &st_q.cnt;
			end
		end
	end

	always_ff @(posedge clock_in) begin
		if (reset_in) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign count_out = st_q.cnt;
	assign prescale_out = st_q.pre;
	assign expired_out = st_q.expired;

endmodule

// File: ccc_core.sv
// execute stage for clear-file, clear-accumulator, call, watchdog-kick and invert-file
// assumes the file register array answers FILE_RDATA_IN combinationally for
// FILE_RD_ADDR_OUT, and program memory answers INSTR_IN for PROG_ADDR_OUT
//
// The implementer's own choice: the address-and-strobe port for the file write.
module ccc_core
	import ccc_pkg::*;
#(
	parameter int STACK_DEPTH = CCC_STACK_DEPTH,
	parameter int CYCLE_CLOCKS = CCC_CYCLE_CLOCKS
) (
	input wire logic CLOCK_IN,
	input wire logic RESET_IN,
	input wire logic [CCC_INSTR_W-1:0] INSTR_IN,
	input wire logic [CCC_LATCH_W-1:0] PC_HIGH_LATCH_IN,
	input wire logic [CCC_DATA_W-1:0] FILE_RDATA_IN,
	output logic [CCC_PC_W-1:0] PROG_ADDR_OUT,
	output logic [CCC_FADDR_W-1:0] FILE_RD_ADDR_OUT,
	output logic FILE_WE_OUT,
	output logic [CCC_FADDR_W-1:0] FILE_WR_ADDR_OUT,
	output logic [CCC_DATA_W-1:0] FILE_WDATA_OUT,
	output logic [CCC_DATA_W-1:0] ACC_OUT,
	output logic ZERO_FLAG_OUT,
	output logic TIMEOUT_FLAG_OUT,
	output logic POWERDOWN_FLAG_OUT,
	output logic [CCC_PC_W-1:0] RETURN_STACK_TOP_OUT,
	output logic [CCC_WATCHDOG_CNT_W-1:0] WATCHDOG_COUNT_OUT,
	output logic [CCC_WATCHDOG_PRE_W-1:0] WATCHDOG_PRESCALE_OUT,
	output logic WATCHDOG_EXPIRED_OUT,
	output logic CYCLE_OUT
);

	localparam int SP_W = (STACK_DEPTH > 1) ? $clog2(STACK_DEPTH) : 1;

	typedef struct packed {
		logic [CCC_PC_W-1:0] pc;
		logic [CCC_PC_W-1:0] ex_pc;
		logic [CCC_INSTR_W-1:0] ir;
		logic ir_valid;
		logic [STACK_DEPTH-1:0][CCC_PC_W-1:0] stack;
		logic [SP_W-1:0] sp;
		logic [CCC_DATA_W-1:0] acc;
		logic zero;
		logic timeout;
		logic powerdown;
		logic [CCC_FADDR_W-1:0] rd_addr;
		logic file_we;
		logic [CCC_FADDR_W-1:0] wr_addr;
		logic [CCC_DATA_W-1:0] wdata;
	} ccc_core_st_t;

	ccc_core_st_t st_q;
	ccc_core_st_t st_d;

	logic cyc_en;
	logic kick;
	logic wd_expired;
	ccc_op_t op;
	logic [CCC_DATA_W-1:0] inverted;
	logic [SP_W-1:0] top_idx;

	ccc_cycle_div #(
		.CYCLES(CYCLE_CLOCKS)
	) u_div (
		.clock_in(CLOCK_IN),
		.reset_in(RESET_IN),
		.cycle_en_out(cyc_en)
	);

	// kick is combinational so counter and prescaler clear in this same cycle
	ccc_watchdog #(
		.PRE_W(CCC_WATCHDOG_PRE_W),
		.CNT_W(CCC_WATCHDOG_CNT_W)
	) u_watchdog (
		.clock_in(CLOCK_IN),
		.reset_in(RESET_IN),
		.tick_in(cyc_en),
		.clear_in(kick),
		.count_out(WATCHDOG_COUNT_OUT),
		.prescale_out(WATCHDOG_PRESCALE_OUT),
		.expired_out(wd_expired)
	);

	// a dropped prefetch decodes as no operation
	assign op = st_q.ir_valid ? ccc_decode(st_q.ir) : OP_NONE;
	assign kick = cyc_en && (op == OP_KICK);
	assign inverted = ~FILE_RDATA_IN;
	assign top_idx = st_q.sp - 1'b1;

	always_comb begin
		st_d = st_q;
		st_d.file_we = 1'b0;
		// expiry clears the timeout flag; a kick in the same cycle wins below
		if (wd_expired) begin
			st_d.timeout = 1'b0;
		end
		if (cyc_en) begin
			// fetch the next word while the current one executes
			st_d.ir = INSTR_IN;
			st_d.ir_valid = 1'b1;
			st_d.ex_pc = st_q.pc;
			st_d.pc = st_q.pc + 1'b1;
			st_d.rd_addr = INSTR_IN[CCC_FADDR_W-1:0];
			case (op)
				OP_CLEAR_FILE: begin
					st_d.file_we = 1'b1;
					st_d.wr_addr = st_q.ir[CCC_FADDR_W-1:0];
					st_d.wdata = CCC_CLEARED;
					st_d.zero = 1'b1;
				end
				OP_CLEAR_ACC: begin
					st_d.acc = CCC_CLEARED;
					st_d.zero = 1'b1;
				end
				OP_KICK: begin
					st_d.timeout = 1'b1;
					st_d.powerdown = 1'b1;
				end
				OP_INVERT: begin
					st_d.zero = (inverted == CCC_CLEARED);
					if (st_q.ir[CCC_DEST_BIT]) begin
						st_d.file_we = 1'b1;
						st_d.wr_addr = st_q.ir[CCC_FADDR_W-1:0];
						st_d.wdata = inverted;
					end else begin
						st_d.acc = inverted;
					end
				end
				OP_CALL: begin
					// flags untouched; the word fetched now is thrown away
					st_d.stack[st_q.sp] = st_q.ex_pc + 1'b1;
					st_d.sp = st_q.sp + 1'b1;
					st_d.pc = {PC_HIGH_LATCH_IN[CCC_LATCH_LSB+:2],
						st_q.ir[CCC_TARGET_W-1:0]};
					st_d.ir_valid = 1'b0;
				end
				default: begin
				end
			endcase
		end
	end

	always_ff @(posedge CLOCK_IN) begin
		if (RESET_IN) begin
			st_q <= '0;
			st_q.pc <= CCC_PC_RST;
			st_q.ex_pc <= CCC_PC_RST;
			st_q.timeout <= CCC_FLAG_RST;
			st_q.powerdown <= CCC_FLAG_RST;
		end else begin
			st_q <= st_d;
		end
	end

	assign PROG_ADDR_OUT = st_q.pc;
	assign FILE_RD_ADDR_OUT = st_q.rd_addr;
	assign FILE_WE_OUT = st_q.file_we;
	assign FILE_WR_ADDR_OUT = st_q.wr_addr;
	assign FILE_WDATA_OUT = st_q.wdata;
	assign ACC_OUT = st_q.acc;
	assign ZERO_FLAG_OUT = st_q.zero;
	assign TIMEOUT_FLAG_OUT = st_q.timeout;
	assign POWERDOWN_FLAG_OUT = st_q.powerdown;
	// stack wraps silently on overflow, like a ring
	assign RETURN_STACK_TOP_OUT = st_q.stack[top_idx];
	assign WATCHDOG_EXPIRED_OUT = wd_expired;
	assign CYCLE_OUT = cyc_en;

	// checks, valid for CYCLE_CLOCKS from 2 to 9

	sequence s_exec(ccc_op_t o);
		cyc_en && (op == o);
	endsequence

	sequence s_bubble;
		!st_q.ir_valid ##[1:8] (cyc_en && (op == OP_NONE));
	endsequence

	property p_clear_file;
		@(posedge CLOCK_IN) disable iff (RESET_IN)
		s_exec(OP_CLEAR_FILE) |=> FILE_WE_OUT && (FILE_WDATA_OUT == 8'h00) && ZERO_FLAG_OUT
			&& (FILE_WR_ADDR_OUT == $past(st_q.ir[6:0]));
	endproperty
	a_clear_file: assert property (p_clear_file) else $error("clear-file result wrong");

	property p_call_push;
		@(posedge CLOCK_IN) disable iff (RESET_IN)
		s_exec(OP_CALL) |=> RETURN_STACK_TOP_OUT == 13'($past(st_q.ex_pc) + 13'h0001);
	endproperty
	a_call_push: assert property (p_call_push) else $error("call pushed wrong address");

	property p_call_low;
		@(posedge CLOCK_IN) disable iff (RESET_IN)
		s_exec(OP_CALL) |=> PROG_ADDR_OUT[10:0] == $past(st_q.ir[10:0]);
	endproperty
	a_call_low: assert property (p_call_low) else $error("call target low bits wrong");

	property p_call_high;
		@(posedge CLOCK_IN) disable iff (RESET_IN)
		s_exec(OP_CALL) |=> PROG_ADDR_OUT[12:11] == $past(PC_HIGH_LATCH_IN[4:3]);
	endproperty
	a_call_high: assert property (p_call_high) else $error("call high bits wrong");

	property p_call_flags;
		@(posedge CLOCK_IN) disable iff (RESET_IN)
		s_exec(OP_CALL) |=> $stable(ZERO_FLAG_OUT) && $stable(ACC_OUT) && !FILE_WE_OUT;
	endproperty
	a_call_flags: assert property (p_call_flags) else $error("call changed state");

	property p_call_bubble;
		@(posedge CLOCK_IN) disable iff (RESET_IN)
		s_exec(OP_CALL) |=> s_bubble ##1 (st_q.ex_pc == $past(PROG_ADDR_OUT));
	endproperty
	a_call_bubble: assert property (p_call_bubble) else $error("call second cycle not idle");

	property p_kick_count;
		@(posedge CLOCK_IN) disable iff (RESET_IN)
		kick |=> (WATCHDOG_COUNT_OUT == 8'h00) && (WATCHDOG_PRESCALE_OUT == 8'h00);
	endproperty
	a_kick_count: assert property (p_kick_count) else $error("watchdog not cleared");

	property p_kick_flags;
		@(posedge CLOCK_IN) disable iff (RESET_IN)
		kick |=> TIMEOUT_FLAG_OUT && POWERDOWN_FLAG_OUT;
	endproperty
	a_kick_flags: assert property (p_kick_flags) else $error("kick flags not set");

	property p_invert_file;
		@(posedge CLOCK_IN) disable iff (RESET_IN)
		cyc_en && (op == OP_INVERT) && st_q.ir[7] |=> FILE_WE_OUT
			&& (FILE_WDATA_OUT == ~$past(FILE_RDATA_IN))
			&& (ZERO_FLAG_OUT == ($past(FILE_RDATA_IN) == 8'hff));
	endproperty
	a_invert_file: assert property (p_invert_file) else $error("invert to file wrong");

	property p_invert_acc;
		@(posedge CLOCK_IN) disable iff (RESET_IN)
		cyc_en && (op == OP_INVERT) && !st_q.ir[7] |=> !FILE_WE_OUT
			&& (ACC_OUT == ~$past(FILE_RDATA_IN));
	endproperty
	a_invert_acc: assert property (p_invert_acc) else $error("invert to accumulator wrong");

	property p_clear_acc;
		@(posedge CLOCK_IN) disable iff (RESET_IN)
		s_exec(OP_CLEAR_ACC) |=> (ACC_OUT == 8'h00) && ZERO_FLAG_OUT && !FILE_WE_OUT;
	endproperty
	a_clear_acc: assert property (p_clear_acc) else $error("clear accumulator wrong");

	// a single-clock cycle would make every clock an execute edge
	property p_we_pulse;
		@(posedge CLOCK_IN) disable iff (RESET_IN)
		(CYCLE_CLOCKS > 1) && FILE_WE_OUT |=> !FILE_WE_OUT;
	endproperty
	a_we_pulse: assert property (p_we_pulse) else $error("file write strobe too long");

	property p_idle_hold;
		@(posedge CLOCK_IN) disable iff (RESET_IN)
		!cyc_en |=> $stable(ACC_OUT) && $stable(ZERO_FLAG_OUT) && $stable(PROG_ADDR_OUT);
	endproperty
	a_idle_hold: assert property (p_idle_hold) else $error("state moved between cycles");

	property p_pc_step;
		@(posedge CLOCK_IN) disable iff (RESET_IN)
		cyc_en && (op != OP_CALL) |=> PROG_ADDR_OUT == 13'($past(PROG_ADDR_OUT) + 13'h0001);
	endproperty
	a_pc_step: assert property (p_pc_step) else $error("fetch address not stepped");

	property p_call_sp;
		@(posedge CLOCK_IN) disable iff (RESET_IN)
		s_exec(OP_CALL) |=> st_q.sp == SP_W'($past(st_q.sp) + 1'b1);
	endproperty
	a_call_sp: assert property (p_call_sp) else $error("call did not push");

	property p_call_status;
		@(posedge CLOCK_IN) disable iff (RESET_IN)
		s_exec(OP_CALL) && !wd_expired |=> $stable(TIMEOUT_FLAG_OUT)
			&& $stable(POWERDOWN_FLAG_OUT);
	endproperty
	a_call_status: assert property (p_call_status) else $error("call changed a status flag");

	property p_expire_clears;
		@(posedge CLOCK_IN) disable iff (RESET_IN)
		wd_expired && !kick |=> !TIMEOUT_FLAG_OUT;
	endproperty
	a_expire_clears: assert property (p_expire_clears) else $error("expiry kept timeout");

	property p_pd_hold;
		@(posedge CLOCK_IN) disable iff (RESET_IN)
		!kick |=> $stable(POWERDOWN_FLAG_OUT);
	endproperty
	a_pd_hold: assert property (p_pd_hold) else $error("powerdown flag moved");

	property p_kick_only;
		@(posedge CLOCK_IN) disable iff (RESET_IN)
		s_exec(OP_KICK) |=> $stable(ACC_OUT) && $stable(ZERO_FLAG_OUT) && !FILE_WE_OUT;
	endproperty
	a_kick_only: assert property (p_kick_only) else $error("kick touched data path");

	property p_nop;
		@(posedge CLOCK_IN) disable iff (RESET_IN)
		s_exec(OP_NONE) |=> $stable(ACC_OUT) && $stable(ZERO_FLAG_OUT) && !FILE_WE_OUT;
	endproperty
	a_nop: assert property (p_nop) else $error("no-op changed state");

	property p_rd_addr;
		@(posedge CLOCK_IN) disable iff (RESET_IN)
		cyc_en |=> FILE_RD_ADDR_OUT == $past(INSTR_IN[6:0]);
	endproperty
	a_rd_addr: assert property (p_rd_addr) else $error("operand address wrong");

	property p_invert_acc_zero;
		@(posedge CLOCK_IN) disable iff (RESET_IN)
		cyc_en && (op == OP_INVERT) && !st_q.ir[7] |=> ZERO_FLAG_OUT == (ACC_OUT == 8'h00);
	endproperty
	a_invert_acc_zero: assert property (p_invert_acc_zero) else $error("invert zero wrong");

	property p_invert_file_acc;
		@(posedge CLOCK_IN) disable iff (RESET_IN)
		cyc_en && (op == OP_INVERT) && st_q.ir[7] |=> $stable(ACC_OUT);
	endproperty
	a_invert_file_acc: assert property (p_invert_file_acc) else $error("invert hit accumulator");

	property p_clear_file_acc;
		@(posedge CLOCK_IN) disable iff (RESET_IN)
		s_exec(OP_CLEAR_FILE) |=> $stable(ACC_OUT);
	endproperty
	a_clear_file_acc: assert property (p_clear_file_acc) else $error("clear-file hit accumulator");

	property p_clear_acc_file;
		@(posedge CLOCK_IN) disable iff (RESET_IN)
		s_exec(OP_CLEAR_ACC) |=> $stable(PROG_ADDR_OUT) || !FILE_WE_OUT;
	endproperty
	a_clear_acc_file: assert property (p_clear_acc_file) else $error("clear-acc wrote file");

	property p_cycle_pulse;
		@(posedge CLOCK_IN) disable iff (RESET_IN)
		(CYCLE_CLOCKS > 1) && cyc_en |=> !cyc_en;
	endproperty
	a_cycle_pulse: assert property (p_cycle_pulse) else $error("cycle pulse too long");

endmodule

// File: tb.sv
// self-checking bench for the clear, call, complement and watchdog-kick block
// drives instruction, latch and file-read ports itself; the file array is modelled here
module tb
	import ccc_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;

	localparam logic [13:0] NOP_WORD = 14'h0000;
	logic clock, reset;
	logic [13:0] instr;
	logic [4:0] latch;
	logic [7:0] rdata;
	logic [12:0] prog_addr, stack_top;
	logic [6:0] rd_addr, wr_addr;
	logic we, zero, tflag, pflag, expired, cycle;
	logic [7:0] wdata, acc, wd_count, wd_pre;
	logic [7:0] fmem [128];
	logic [12:0] fa;
	int fails = 0;
	int n_tests = 0;

	ccc_core u_dut (.CLOCK_IN(clock), .RESET_IN(reset), .INSTR_IN(instr),
		.PC_HIGH_LATCH_IN(latch), .FILE_RDATA_IN(rdata), .PROG_ADDR_OUT(prog_addr),
		.FILE_RD_ADDR_OUT(rd_addr), .FILE_WE_OUT(we), .FILE_WR_ADDR_OUT(wr_addr),
		.FILE_WDATA_OUT(wdata), .ACC_OUT(acc), .ZERO_FLAG_OUT(zero),
		.TIMEOUT_FLAG_OUT(tflag), .POWERDOWN_FLAG_OUT(pflag),
		.RETURN_STACK_TOP_OUT(stack_top), .WATCHDOG_COUNT_OUT(wd_count),
		.WATCHDOG_PRESCALE_OUT(wd_pre), .WATCHDOG_EXPIRED_OUT(expired), .CYCLE_OUT(cycle));

	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end

	function automatic logic [7:0] init_val(input int i);
		return 8'(i) ^ 8'h3c;
	endfunction

	// file array answers one clock late; still settled well before the next cycle pulse
	always @(posedge clock) begin
		if (we === 1'b1) begin
			fmem[wr_addr] <= wdata;
		end
		rdata <= fmem[rd_addr];
	end

	task automatic print_verdict();
		$display("comparisons %0d mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	task automatic report(input string nm, input logic [15:0] e, input logic [15:0] g);
		n_tests++;
		if (g !== e) begin
			fails++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic chk1(input string nm, input logic e, input logic g);
		report(nm, {15'h0000, e}, {15'h0000, g});
	endtask

	task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
		report(nm, {8'h00, e}, {8'h00, g});
	endtask

	task automatic chk13(input string nm, input logic [12:0] e, input logic [12:0] g);
		report(nm, {3'h0, e}, {3'h0, g});
	endtask

	// hands one word to the fetch port and returns on the edge that takes it
	task automatic step(input logic [13:0] w);
		int n;
		n = 0;
		@(posedge clock);
		instr <= w;
		do begin
			@(negedge clock);
			n++;
		end while (cycle !== 1'b1 && n < 16);
		if (n >= 16) begin
			fails++;
			$display("[ERR] cycle_pulse expected 1 seen 0");
			print_verdict();
		end
		fa = prog_addr;
		@(posedge clock);
	endtask

	task automatic t_clear_file();
		step(14'h0192);
		step(NOP_WORD);
		@(negedge clock);
		chk1("clr_we", 1'b1, we);
		chk8("clr_addr", 8'h12, {1'b0, wr_addr});
		chk8("clr_data", 8'h00, wdata);
		chk1("clr_zero", 1'b1, zero);
		@(negedge clock);
		chk1("clr_we_len", 1'b0, we);
	endtask

	// register 12 was just cleared, so its complement is all ones
	task automatic t_invert();
		step(14'h0992);
		step(14'h0912);
		@(negedge clock);
		chk1("inv1_we", 1'b1, we);
		chk8("inv1_data", 8'hff, wdata);
		chk1("inv1_zero", 1'b0, zero);
		step(14'h0921);
		@(negedge clock);
		chk8("inv2_acc", 8'h00, acc);
		chk1("inv2_zero", 1'b1, zero);
		chk1("inv2_we", 1'b0, we);
		step(NOP_WORD);
		@(negedge clock);
		chk8("inv3_acc", ~init_val(8'h21), acc);
		chk1("inv3_zero", 1'b0, zero);
	endtask

	task automatic t_clear_acc();
		step(14'h017f);
		step(NOP_WORD);
		@(negedge clock);
		chk8("clracc_acc", 8'h00, acc);
		chk1("clracc_zero", 1'b1, zero);
		chk1("clracc_we", 1'b0, we);
	endtask

	// victim word would write the file and set zero if it were not dropped
	task automatic t_call(input logic [10:0] k, input logic [4:0] lt);
		logic z;
		logic [12:0] a;
		logic [12:0] tgt;
		@(posedge clock);
		latch <= lt;
		z = zero;
		tgt = {lt[4:3], k};
		step(14'h2000 | {3'b000, k});
		a = fa;
		step(14'h01a1);
		@(negedge clock);
		chk13("call_pc", tgt, prog_addr);
		chk13("call_tos", a + 13'h0001, stack_top);
		chk1("call_zero", z, zero);
		step(NOP_WORD);
		chk13("call_fetch", tgt, fa);
		@(negedge clock);
		chk1("call_drop_we", 1'b0, we);
		chk1("call_drop_zero", z, zero);
	endtask

	task automatic t_kick();
		step(14'h0064);
		step(NOP_WORD);
		@(negedge clock);
		chk8("kick_count", 8'h00, wd_count);
		chk8("kick_pre", 8'h00, wd_pre);
		chk1("kick_to", 1'b1, tflag);
		chk1("kick_pd", 1'b1, pflag);
	endtask

	initial begin
		reset = 1'b1;
		instr = NOP_WORD;
		latch = 5'h00;
		for (int i = 0; i < 128; i++) begin
			fmem[i] = init_val(i);
		end
		repeat (2) @(posedge clock);
		reset <= 1'b0;
		@(negedge clock);
		chk13("rst_pc", 13'h0000, prog_addr);
		chk8("rst_acc", 8'h00, acc);
		chk1("rst_to", 1'b1, tflag);
		chk1("rst_pd", 1'b1, pflag);
		t_clear_file();
		t_invert();
		t_call(11'h5a5, 5'h17);
		t_clear_acc();
		t_call(11'h7ff, 5'h08);
		t_kick();
		print_verdict();
	end
endmodule
